// File: common/rcve_defines.svh
// Purpose: Register offsets, field positions, reset values for the reset and voltage event block
// Assumes: Avalon-MM, 32-bit data, byte addresses
// Notes:   Included by bare name
`ifndef RCVE_DEFINES_SVH
`define RCVE_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define RCVE_OFS_CAUSE       8'h00
`define RCVE_OFS_CAUSE_CLR   8'h04
`define RCVE_OFS_SLEEP_CFG   8'h08
`define RCVE_OFS_SLEEP_CTL   8'h0c
`define RCVE_OFS_USB_PLL     8'h10
`define RCVE_OFS_VEV_STAT    8'h14
`define RCVE_OFS_VEV_CFG     8'h18
`define RCVE_OFS_RST_BEHAV   8'h1c
`define RCVE_OFS_STATUS      8'h20

// ==========================================================
// Cause bit positions
`define RCVE_CAUSE_EXT       0
`define RCVE_CAUSE_POR       1
`define RCVE_CAUSE_BOR       2
`define RCVE_CAUSE_WDOG0     3
`define RCVE_CAUSE_SW        4
`define RCVE_CAUSE_WDOG1     5
`define RCVE_CAUSE_HIB       6
`define RCVE_CAUSE_HSR       7

// Voltage event status bits
`define RCVE_VEV_MAIN        0
`define RCVE_VEV_ANALOG      1

// Reset behaviour bits: 1 selects full power-on, 0 system reset
`define RCVE_BEH_WDOG0       0
`define RCVE_BEH_WDOG1       1
`define RCVE_BEH_BOR         2
`define RCVE_BEH_EXT         3

// ==========================================================
// Reset values
`define RCVE_RST_VEV_CFG     4'h0
`define RCVE_RST_BEHAV       4'h0
`define RCVE_RST_SLEEP_CFG   3'h0

`endif

// File: common/rcve_pkg.sv
// Purpose: Types for the reset and voltage event block
// Assumes: Nothing
// Notes:   Constants live in rcve_defines.svh
package rcve_pkg;

  // ========================================================
  // Brown-out response encoding
  typedef enum logic [1:0] {
    RCVE_ACT_NONE,
    RCVE_ACT_IRQ,
    RCVE_ACT_NMI,
    RCVE_ACT_RESET
  } rcve_action_t;

  // SRAM sleep power level
  typedef enum logic [1:0] {
    RCVE_SRAM_FULL,
    RCVE_SRAM_STANDBY,
    RCVE_SRAM_LOWEST
  } rcve_sram_t;

  // Sleep power configuration
  typedef struct packed {
    rcve_sram_t sram;
    logic       flash_reduced;
  } rcve_sleep_cfg_t;

  // Reset requests to the power sequencer
  typedef struct packed {
    logic full_por;
    logic sys_rst;
  } rcve_rst_req_t;

endpackage

// File: logic/rcve_core.sv
// Purpose: Reset cause record, sleep power control, USB PLL gate, brown-out events
// Assumes: Single 100 MHz clock; brown-out and reset source inputs are asynchronous pins
// Notes:   Cause and voltage-event state sit on the power-on domain only
//
// Contract
// - Cause flags stay set until software clear or power-on reset.
// - Cause read returns OR of all causes since last clear.
// - Eight causes recorded: service, hibernate, wdog1, software, wdog0, brownout, POR, pin.
// - Cause clear drops only masked flags; later reset sets flag again.
// - Sleep halts processor; clock gating keeps only sleep-enabled peripherals running.
// - Flash sleep power is full or reduced.
// - SRAM sleep power is full, standby or lowest.
// - USB PLL off stops the physical layer, registers stay reachable.
// - Falling below threshold on a monitored rail raises a voltage event.
// - Two voltage flags, main and analog rail, read as one word.
// - Voltage flags survive system and software resets, cleared only by software or power-on reset.
// - Voltage clear drops masked flags; writing read value clears all.
// - Analog rail response is none, interrupt, NMI or reset.
// - Main rail response is independently none, interrupt, NMI or reset.
// - Brown-out reset kind comes from the brown-out behaviour entry.
// - Each configurable source picks full power-on or system reset (only the brown-out entry drives RESET_REQ here; the others are just stored).
// - Software reset defaults registers but keeps cause record plus software flag.
//
// The placing of the registers and register access over Avalon-MM are this design's own decisions.
`timescale 1ns/100ps
`include "rcve_defines.svh"

module rcve_core #(
  parameter int ADDR_W = 8
) (
  // Clock and power-on reset
  input  wire logic                   CLOCK,
  input  wire logic                   RESETN,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0]      AVS_ADDRESS,
  input  wire logic                   AVS_READ,
  input  wire logic                   AVS_WRITE,
  input  wire logic [31:0]            AVS_WRITEDATA,
  input  wire logic [3:0]             AVS_BYTEENABLE,
  output logic [31:0]                 AVS_READDATA,
  output logic                        AVS_WAITREQUEST,
  // Asynchronous reset sources and rail comparators
  input  wire logic                   SYS_RESET_EVENT,
  input  wire logic [7:0]             CAUSE_EVENT,
  input  wire logic                   MAIN_RAIL_LOW,
  input  wire logic                   ANALOG_RAIL_LOW,
  // Sleep control
  input  wire logic                   WAKE_EVENT,
  output logic                        CPU_HALT,
  output logic                        PERIPH_GATE_SLEEP,
  output rcve_pkg::rcve_sleep_cfg_t   SLEEP_POWER,
  output logic                        SLEEP_ACTIVE,
  // USB PLL
  output logic                        USB_PLL_ON,
  output logic                        USB_PHY_ENABLE,
  // Event outputs
  output logic                        SYSCTL_IRQ,
  output logic                        NMI_REQ,
  output rcve_pkg::rcve_rst_req_t     RESET_REQ
);

  // Offsets reach 0x20, so a narrower address cannot decode the map
  if (ADDR_W < 6) begin : g_addr_check
    $error("ADDR_W too small for the register map");
  end

  // ========================================================
  // Reset release and input synchronisers
  logic [1:0]  rst_sync;
  logic        rst_n;
  logic [11:0] in_meta;
  logic [11:0] in_sync;
  logic [11:0] in_prev;

  always_ff @(posedge CLOCK or negedge RESETN) begin
    if (!RESETN) begin
      rst_sync <= 2'h0;
    end else begin
      rst_sync <= {rst_sync[0], 1'b1};
    end
  end
  assign rst_n = rst_sync[1];

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      in_meta <= 12'h000;
      in_sync <= 12'h000;
      in_prev <= 12'h000;
    end else begin
      in_meta <= {WAKE_EVENT, SYS_RESET_EVENT, ANALOG_RAIL_LOW, MAIN_RAIL_LOW, CAUSE_EVENT};
      in_sync <= in_meta;
      in_prev <= in_sync;
    end
  end

  logic [7:0] cause_rise;
  logic [1:0] rail_rise;
  logic       sys_rst;
  logic       wake;
  assign cause_rise = in_sync[7:0] & ~in_prev[7:0];
  assign rail_rise  = in_sync[9:8] & ~in_prev[9:8];
  assign sys_rst    = in_sync[10];
  assign wake       = in_sync[11];

  // ========================================================
  // Bus decode
  logic        wr_en;
  logic [31:0] wdata;
  logic        wait_done;

  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
    hit = (a == ADDR_W'(ofs));
  endfunction

  // One wait state on each access so read data come from a flip-flop
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      wait_done <= 1'b0;
    end else begin
      wait_done <= (AVS_READ || AVS_WRITE) && !wait_done;
    end
  end
  assign AVS_WAITREQUEST = (AVS_READ || AVS_WRITE) && !wait_done;
  assign wr_en = AVS_WRITE && wait_done;

  always_comb begin
    wdata = 32'h0;
    for (int i = 0; i < 4; i++) begin
      wdata[i*8 +: 8] = AVS_BYTEENABLE[i] ? AVS_WRITEDATA[i*8 +: 8] : 8'h00;
    end
  end

  // ========================================================
  // Reset cause record: power-on domain only, survives system resets
  logic [7:0] cause;
  logic [7:0] sw_rst_pulse_cause;
  logic [7:0] bor_cause;
  logic       sw_rst_pulse;
  logic       cause_clr_hit;
  assign cause_clr_hit = wr_en && hit(AVS_ADDRESS, `RCVE_OFS_CAUSE_CLR);

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      cause <= 8'h02;
    end else begin
      // Set wins over a clear in the same cycle
      cause <= (cause & ~(cause_clr_hit ? wdata[7:0] : 8'h00))
               | cause_rise | sw_rst_pulse_cause | bor_cause;
    end
  end

  // ========================================================
  // Voltage events: sticky, cleared only by software or power-on reset
  logic [1:0] vev;
  logic       vev_clr_hit;
  assign vev_clr_hit = wr_en && hit(AVS_ADDRESS, `RCVE_OFS_VEV_STAT);

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      vev <= 2'h0;
    end else begin
      vev <= (vev & ~(vev_clr_hit ? wdata[1:0] : 2'h0)) | rail_rise;
    end
  end

  // ========================================================
  // Configuration registers: return to defaults on any system reset
  rcve_pkg::rcve_action_t    act_main;
  rcve_pkg::rcve_action_t    act_analog;
  logic [3:0]                behav;
  rcve_pkg::rcve_sleep_cfg_t sleep_cfg;
  logic                      clk_gating;
  logic                      usb_pll;
  logic                      cfg_rst;
  assign cfg_rst = sys_rst || sw_rst_pulse;

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      act_main   <= rcve_pkg::RCVE_ACT_NONE;
      act_analog <= rcve_pkg::RCVE_ACT_NONE;
      behav      <= `RCVE_RST_BEHAV;
      sleep_cfg  <= rcve_pkg::rcve_sleep_cfg_t'(`RCVE_RST_SLEEP_CFG);
      clk_gating <= 1'b0;
      usb_pll    <= 1'b0;
    end else if (cfg_rst) begin
      act_main   <= rcve_pkg::RCVE_ACT_NONE;
      act_analog <= rcve_pkg::RCVE_ACT_NONE;
      behav      <= `RCVE_RST_BEHAV;
      sleep_cfg  <= rcve_pkg::rcve_sleep_cfg_t'(`RCVE_RST_SLEEP_CFG);
      clk_gating <= 1'b0;
      usb_pll    <= 1'b0;
    end else if (wr_en) begin
      if (hit(AVS_ADDRESS, `RCVE_OFS_VEV_CFG)) begin
        act_main   <= rcve_pkg::rcve_action_t'(wdata[1:0]);
        act_analog <= rcve_pkg::rcve_action_t'(wdata[3:2]);
      end
      if (hit(AVS_ADDRESS, `RCVE_OFS_RST_BEHAV)) begin
        behav <= wdata[3:0];
      end
      if (hit(AVS_ADDRESS, `RCVE_OFS_SLEEP_CFG)) begin
        sleep_cfg.flash_reduced <= wdata[0];
        // The unused fourth code falls back to the lowest level
        sleep_cfg.sram <= (wdata[2:1] == 2'h3) ? rcve_pkg::RCVE_SRAM_LOWEST
                          : rcve_pkg::rcve_sram_t'(wdata[2:1]);
        clk_gating <= wdata[3];
      end
      if (hit(AVS_ADDRESS, `RCVE_OFS_USB_PLL)) begin
        usb_pll <= wdata[0];
      end
    end
  end

  // ========================================================
  // Software reset request and sleep entry
  logic sleeping;

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      sw_rst_pulse <= 1'b0;
    end else begin
      sw_rst_pulse <= wr_en && hit(AVS_ADDRESS, `RCVE_OFS_SLEEP_CTL) && wdata[1];
    end
  end
  assign sw_rst_pulse_cause = {3'h0, sw_rst_pulse, 4'h0};

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      sleeping <= 1'b0;
    end else if (wake || cfg_rst) begin
      sleeping <= 1'b0;
    end else if (wr_en && hit(AVS_ADDRESS, `RCVE_OFS_SLEEP_CTL) && wdata[0]) begin
      sleeping <= 1'b1;
    end
  end

  assign CPU_HALT          = sleeping;
  assign PERIPH_GATE_SLEEP = sleeping && clk_gating;
  assign SLEEP_ACTIVE      = sleeping;
  assign SLEEP_POWER       = sleeping ? sleep_cfg
                             : rcve_pkg::rcve_sleep_cfg_t'(`RCVE_RST_SLEEP_CFG);
  assign USB_PLL_ON        = usb_pll;
  assign USB_PHY_ENABLE    = usb_pll;

  // ========================================================
  // Brown-out responses
  logic [1:0] rst_hit;
  logic       nmi_q;
  assign rst_hit = {rail_rise[1] && act_analog == rcve_pkg::RCVE_ACT_RESET,
                    rail_rise[0] && act_main == rcve_pkg::RCVE_ACT_RESET};
  assign bor_cause = {5'h00, |rst_hit, 2'h0};

  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      RESET_REQ <= rcve_pkg::rcve_rst_req_t'(2'h0);
      nmi_q     <= 1'b0;
    end else begin
      RESET_REQ.full_por <= (|rst_hit) && behav[`RCVE_BEH_BOR];
      RESET_REQ.sys_rst  <= (|rst_hit) && !behav[`RCVE_BEH_BOR];
      nmi_q <= (rail_rise[0] && act_main == rcve_pkg::RCVE_ACT_NMI)
            || (rail_rise[1] && act_analog == rcve_pkg::RCVE_ACT_NMI);
    end
  end
  assign NMI_REQ = nmi_q;

  assign SYSCTL_IRQ = (vev[0] && act_main == rcve_pkg::RCVE_ACT_IRQ)
                   || (vev[1] && act_analog == rcve_pkg::RCVE_ACT_IRQ);

  // ========================================================
  // Read data
  always_ff @(posedge CLOCK or negedge rst_n) begin
    if (!rst_n) begin
      AVS_READDATA <= 32'h0;
    end else if (AVS_READ && !wait_done) begin
      AVS_READDATA <= 32'h0;
      if (hit(AVS_ADDRESS, `RCVE_OFS_CAUSE))     AVS_READDATA <= {24'h0, cause};
      if (hit(AVS_ADDRESS, `RCVE_OFS_SLEEP_CFG)) AVS_READDATA <= {28'h0, clk_gating, sleep_cfg};
      if (hit(AVS_ADDRESS, `RCVE_OFS_USB_PLL))   AVS_READDATA <= {31'h0, usb_pll};
      if (hit(AVS_ADDRESS, `RCVE_OFS_VEV_STAT))  AVS_READDATA <= {30'h0, vev};
      if (hit(AVS_ADDRESS, `RCVE_OFS_VEV_CFG))   AVS_READDATA <= {28'h0, act_analog, act_main};
      if (hit(AVS_ADDRESS, `RCVE_OFS_RST_BEHAV)) AVS_READDATA <= {28'h0, behav};
      if (hit(AVS_ADDRESS, `RCVE_OFS_STATUS))    AVS_READDATA <= {30'h0, SYSCTL_IRQ, sleeping};
    end
  end

  // ========================================================
  // Checks
  property p_cause_sticky;
    @(posedge CLOCK) disable iff (!rst_n)
      !cause_clr_hit |=> ((cause & $past(cause)) == $past(cause));
  endproperty
  a_cause_sticky: assert property (p_cause_sticky) else $error("cause flag lost");

  property p_vev_set;
    @(posedge CLOCK) disable iff (!rst_n)
      rail_rise[0] |=> vev[0];
  endproperty
  a_vev_set: assert property (p_vev_set) else $error("main rail event not recorded");

  property p_vev_keep;
    @(posedge CLOCK) disable iff (!rst_n)
      (vev[1] && !vev_clr_hit) |=> vev[1];
  endproperty
  a_vev_keep: assert property (p_vev_keep) else $error("analog flag lost");

  property p_vev_clr;
    @(posedge CLOCK) disable iff (!rst_n)
      (vev_clr_hit && wdata[1:0] == 2'h3 && rail_rise == 2'h0) |=> vev == 2'h0;
  endproperty
  a_vev_clr: assert property (p_vev_clr) else $error("masked clear failed");

  property p_irq;
    @(posedge CLOCK) disable iff (!rst_n)
      (vev[1] && act_analog == rcve_pkg::RCVE_ACT_IRQ) |-> SYSCTL_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_bor_kind;
    @(posedge CLOCK) disable iff (!rst_n)
      (|rst_hit) |=> (RESET_REQ.full_por == $past(behav[`RCVE_BEH_BOR])) && cause[2];
  endproperty
  a_bor_kind: assert property (p_bor_kind) else $error("wrong brown-out reset kind");

  property p_sw_cause;
    @(posedge CLOCK) disable iff (!rst_n)
      sw_rst_pulse |=> cause[`RCVE_CAUSE_SW] && usb_pll == 1'b0;
  endproperty
  a_sw_cause: assert property (p_sw_cause) else $error("software reset handling");

  property p_phy;
    @(posedge CLOCK) disable iff (!rst_n)
      !USB_PLL_ON |-> !USB_PHY_ENABLE;
  endproperty
  a_phy: assert property (p_phy) else $error("phy on without pll");

  property p_nmi;
    @(posedge CLOCK) disable iff (!rst_n)
      (rail_rise[1] && act_analog == rcve_pkg::RCVE_ACT_NMI) |=> NMI_REQ;
  endproperty
  a_nmi: assert property (p_nmi) else $error("analog rail NMI missing");

  property p_main_reset;
    @(posedge CLOCK) disable iff (!rst_n)
      (rail_rise[0] && act_main == rcve_pkg::RCVE_ACT_RESET)
      |=> (RESET_REQ.full_por ^ RESET_REQ.sys_rst);
  endproperty
  a_main_reset: assert property (p_main_reset) else $error("main rail reset missing");

  property p_halt;
    @(posedge CLOCK) disable iff (!rst_n)
      (wr_en && hit(AVS_ADDRESS, `RCVE_OFS_SLEEP_CTL) && wdata[0] && !wake && !cfg_rst)
      |=> CPU_HALT;
  endproperty
  a_halt: assert property (p_halt) else $error("sleep entry did not halt");

endmodule

// File: testbench/reset_cause_voltage_event_bench.sv
// Purpose: Self-checking bench for the reset cause and voltage event block
// Assumes: Slave answers whenever waitrequest drops; pin events land within six cycles
// Notes:   NMI and reset request pulses are counted by a monitor process
`timescale 1ns/100ps
`include "rcve_defines.svh"

module reset_cause_voltage_event_bench;
  // ==========================================================
  // Design signals
  logic                      clock   = 1'b0;
  logic                      resetn  = 1'b0;
  logic [7:0]                adr     = 8'h00;
  logic                      rd      = 1'b0;
  logic                      wr      = 1'b0;
  logic [31:0]               wdata   = 32'h0;
  logic                      sys_ev  = 1'b0;
  logic [7:0]                cause_ev = 8'h00;
  logic                      main_low = 1'b0;
  logic                      an_low  = 1'b0;
  logic                      wake    = 1'b0;
  logic [31:0]               rdata;
  logic                      waitreq, halt, gate, sleeping, pll, phy, irq, nmi;
  rcve_pkg::rcve_sleep_cfg_t slp_pwr;
  rcve_pkg::rcve_rst_req_t   rst_req;
  int                        num_errors = 0;
  int                        tests_run  = 0;
  int                        nmi_n = 0, por_n = 0, sys_n = 0;

  always #5 clock = ~clock;

  rcve_core dut_u (
    .CLOCK(clock), .RESETN(resetn),
    .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wdata),
    .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
    .SYS_RESET_EVENT(sys_ev), .CAUSE_EVENT(cause_ev),
    .MAIN_RAIL_LOW(main_low), .ANALOG_RAIL_LOW(an_low), .WAKE_EVENT(wake),
    .CPU_HALT(halt), .PERIPH_GATE_SLEEP(gate), .SLEEP_POWER(slp_pwr),
    .SLEEP_ACTIVE(sleeping), .USB_PLL_ON(pll), .USB_PHY_ENABLE(phy),
    .SYSCTL_IRQ(irq), .NMI_REQ(nmi), .RESET_REQ(rst_req)
  );

  // One-cycle pulses would be missed by sampling after a task, so count them here
  always @(posedge clock) begin
    if (nmi === 1'b1) nmi_n++;
    if (rst_req.full_por === 1'b1) por_n++;
    if (rst_req.sys_rst === 1'b1) sys_n++;
  end

  // ==========================================================
  // Helpers
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Request held until the rising edge that sees waitrequest low; data taken there
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clock);
    rd <= ~w;
    wr <= w;
    adr <= a;
    wdata <= d;
    do begin
      @(posedge clock);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    chk("handshake", n < 20, 1'b1);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(what, q, exp);
  endtask

  task automatic raise(input int n);
    @(posedge clock);
    cause_ev <= 8'h01 << n;
    cyc(6);
    cause_ev <= 8'h00;
    cyc(2);
  endtask

  task automatic sys_reset;
    @(posedge clock);
    sys_ev <= 1'b1;
    cyc(4);
    sys_ev <= 1'b0;
    cyc(6);
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_regs;
    rdc("cause at power-on", `RCVE_OFS_CAUSE, 32'h02);
    rdc("vev at power-on", `RCVE_OFS_VEV_STAT, 32'h0);
    wr32(`RCVE_OFS_CAUSE, 32'hff);
    rdc("cause read-only", `RCVE_OFS_CAUSE, 32'h02);
    wr32(8'h24, 32'hff);
    rdc("unmapped", 8'h24, 32'h0);
  endtask

  task automatic t_cause;
    logic [7:0] e;
    wr32(`RCVE_OFS_CAUSE_CLR, 32'hff);
    rdc("cause cleared", `RCVE_OFS_CAUSE, 32'h0);
    e = 8'h00;
    for (int n = 0; n < 8; n++) begin
      raise(n);
      e[n] = 1'b1;
      rdc("cause accumulate", `RCVE_OFS_CAUSE, {24'h0, e});
    end
    sys_reset();
    rdc("cause after sys reset", `RCVE_OFS_CAUSE, 32'hff);
    wr32(`RCVE_OFS_CAUSE_CLR, 32'h0f);
    rdc("cause masked clear", `RCVE_OFS_CAUSE, 32'hf0);
    raise(0);
    rdc("cause set again", `RCVE_OFS_CAUSE, 32'hf1);
    wr32(`RCVE_OFS_CAUSE_CLR, 32'hff);
  endtask

  task automatic t_sleep;
    logic [1:0] s;
    for (int i = 0; i < 16; i++) begin
      s = (i[2:1] == 2'h3) ? 2'h2 : i[2:1];
      wr32(`RCVE_OFS_SLEEP_CFG, i);
      chk("power awake", slp_pwr, 3'h0);
      wr32(`RCVE_OFS_SLEEP_CTL, 32'h1);
      cyc(2);
      chk("halt", halt, 1'b1);
      chk("sleep active", sleeping, 1'b1);
      chk("gating", gate, i[3]);
      chk("sleep power", slp_pwr, {s, i[0]});
      rdc("status sleeping", `RCVE_OFS_STATUS, 32'h1);
      @(posedge clock);
      wake <= 1'b1;
      cyc(5);
      wake <= 1'b0;
      cyc(3);
      chk("halt after wake", halt, 1'b0);
      chk("power after wake", slp_pwr, 3'h0);
    end
    wr32(`RCVE_OFS_SLEEP_CFG, 32'h0);
  endtask

  task automatic t_usb;
    wr32(`RCVE_OFS_USB_PLL, 32'h1);
    cyc(1);
    chk("pll on", {pll, phy}, 2'h3);
    wr32(`RCVE_OFS_USB_PLL, 32'h0);
    cyc(1);
    chk("pll off", {pll, phy}, 2'h0);
    rdc("usb reg reachable", `RCVE_OFS_USB_PLL, 32'h0);
  endtask

  task automatic t_vev;
    int n0, p0, s0;
    for (int r = 0; r < 2; r++) begin
      for (int a = 0; a < 4; a++) begin
        wr32(`RCVE_OFS_VEV_CFG, a << (2 * r));
        wr32(`RCVE_OFS_RST_BEHAV, r << `RCVE_BEH_BOR);
        n0 = nmi_n;
        p0 = por_n;
        s0 = sys_n;
        @(posedge clock);
        if (r == 0) main_low <= 1'b1;
        else an_low <= 1'b1;
        cyc(8);
        main_low <= 1'b0;
        an_low <= 1'b0;
        cyc(2);
        chk("irq level", irq, a == 1);
        chk("nmi pulses", nmi_n - n0, a == 2);
        chk("por pulses", por_n - p0, a == 3 && r == 1);
        chk("sys pulses", sys_n - s0, a == 3 && r == 0);
        rdc("vev flag", `RCVE_OFS_VEV_STAT, 32'h1 << r);
        rdc("bor cause", `RCVE_OFS_CAUSE, (a == 3) ? 32'h04 : 32'h0);
        wr32(`RCVE_OFS_CAUSE_CLR, 32'hff);
        wr32(`RCVE_OFS_VEV_STAT, 32'h1 << r);
        rdc("vev cleared", `RCVE_OFS_VEV_STAT, 32'h0);
        chk("irq dropped", irq, 1'b0);
      end
    end
    wr32(`RCVE_OFS_VEV_CFG, 32'h5);
    @(posedge clock);
    main_low <= 1'b1;
    an_low <= 1'b1;
    cyc(8);
    rdc("both flags", `RCVE_OFS_VEV_STAT, 32'h3);
    sys_reset();
    rdc("flags survive", `RCVE_OFS_VEV_STAT, 32'h3);
    rdc("cfg defaulted", `RCVE_OFS_VEV_CFG, 32'h0);
    chk("irq off by cfg", irq, 1'b0);
    main_low <= 1'b0;
    an_low <= 1'b0;
    wr32(`RCVE_OFS_VEV_STAT, 32'h1);
    rdc("masked vev clear", `RCVE_OFS_VEV_STAT, 32'h2);
  endtask

  task automatic t_swrst;
    wr32(`RCVE_OFS_SLEEP_CFG, 32'h5);
    wr32(`RCVE_OFS_USB_PLL, 32'h1);
    wr32(`RCVE_OFS_RST_BEHAV, 32'hf);
    wr32(`RCVE_OFS_CAUSE_CLR, 32'hff);
    raise(0);
    wr32(`RCVE_OFS_SLEEP_CTL, 32'h2);
    cyc(3);
    rdc("cause kept plus sw", `RCVE_OFS_CAUSE, 32'h11);
    rdc("sleep cfg default", `RCVE_OFS_SLEEP_CFG, 32'h0);
    rdc("behaviour default", `RCVE_OFS_RST_BEHAV, 32'h0);
    chk("pll default", pll, 1'b0);
  endtask

  // ==========================================================
  // Run control
  task automatic tally_and_finish;
    if (num_errors == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    cyc(4);
    resetn <= 1'b1;
    cyc(4);
    t_regs();
    t_cause();
    t_sleep();
    t_usb();
    t_vev();
    t_swrst();
    tally_and_finish();
  end

  // Whole run is under a thousand cycles; this margin only trips on a hang
  initial begin
    #200us;
    num_errors++;
    tally_and_finish();
  end
endmodule
